/* File: shared/bpc_pkg.sv */
// Shared constants, types and decode helpers for the buck control and supervision block.
package bpc_pkg;

	// ************************************************************
	// Register map (byte addresses on the APB port)
	// ************************************************************
	localparam int unsigned ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h04;
	localparam logic [ADDR_W-1:0] MASK_OFF = 8'h08;
	localparam logic [ADDR_W-1:0] STATE_OFF = 8'h0C;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int unsigned CTRL_EN_BIT = 0;
	localparam int unsigned CTRL_LDO_BIT = 1;
	localparam int unsigned CTRL_CL_BIT = 2;
	localparam int unsigned CTRL_VSEL_LSB = 3;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic CTRL_LDO_RST = 1'b1;
	localparam logic CTRL_CL_RST = 1'b0;
	localparam int unsigned STAT_W = 3;
	localparam int unsigned STAT_UV_BIT = 0;
	localparam int unsigned STAT_OCP_BIT = 1;
	localparam int unsigned STAT_DRV_BIT = 2;
	localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
	localparam logic [STAT_W-1:0] MASK_RST = 3'h0;
	localparam int unsigned ST_HS_BIT = 0;
	localparam int unsigned ST_LS_BIT = 1;
	localparam int unsigned ST_LDO_BIT = 2;
	localparam int unsigned ST_CMP_BIT = 3;
	localparam int unsigned ST_UV_BIT = 4;
	localparam int unsigned ST_CLL_BIT = 5;
	localparam int unsigned ST_RRQ_BIT = 6;

	// ************************************************************
	// Encodings
	// ************************************************************
	typedef enum logic [1:0] {VSEL_3V3, VSEL_4V0, VSEL_5V0, VSEL_5V7} bpc_vsel_type;
	localparam logic LDO_SRC_MOTOR = 1'b1;
	localparam logic CL_SEL_600MA = 1'b0;
	localparam logic CL_SEL_150MA = 1'b1;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CLK_PERIOD_PS = 5000;
	localparam int unsigned RST_PULSE_NS = 1000;
	localparam int unsigned RST_PULSE_CYC = (RST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// The internal regulator may only draw from the converter at the two high output settings.
	function automatic logic bpc_buck_feed_ok(input bpc_vsel_type vsel);
		return (vsel == VSEL_5V0) || (vsel == VSEL_5V7);
	endfunction

endpackage

/* File: tb/bpc_load_model.sv */
// Behavioural inductor and load seen from the converter switch node.
`timescale 1ns/10ps
module bpc_load_model (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Switch and selects
	input wire logic i_hs_on,
	input wire logic [1:0] i_vsel,
	input wire logic i_cl_sel,
	// Bench overrides
	input wire logic i_ovr,
	input wire logic i_ovr_below,
	input wire logic i_ovr_cl,
	// Comparators
	output logic o_below_ref,
	output logic o_cl_hit
);
	int v_q;
	int i_q;

	// The output charges while the high side conducts and sags under load otherwise.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			v_q <= 0;
			i_q <= 0;
		end else if (i_hs_on) begin
			v_q <= v_q + 2;
			i_q <= i_q + 1;
		end else begin
			v_q <= (v_q > 0) ? v_q - 1 : 0;
			i_q <= 0;
		end
	end

	// The lower limit trips after fewer conducting cycles, as a smaller peak current would.
	assign o_below_ref = i_ovr ? i_ovr_below : (v_q < 10 + 4 * int'(i_vsel));
	assign o_cl_hit = i_ovr ? i_ovr_cl : (i_q > (i_cl_sel ? 2 : 6));
endmodule

/* File: tb/tb_top.sv */
// Self-checking testbench for the buck control and supervision block.
`timescale 1ns/10ps
module tb_top;
	import bpc_pkg::*;
	localparam int unsigned RST_CYC = 8;
	logic i_clk, i_resetn, i_psel, i_penable, i_pwrite, err, hs_prev;
	logic [7:0] i_paddr;
	logic [31:0] i_pwdata, o_prdata, rd;
	logic o_pready, o_pslverr, below, cl_hit, i_ocp, i_uv, o_hs_on, o_ls_on, cl_out, ldo_out;
	logic o_rst_req, o_fault_n, o_irq, ovr, ovr_below, ovr_cl;
	bpc_vsel_type ref_out;
	int bad_count = 0;
	int checked = 0;
	int cycles = 0;
	int rises = 0;

	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	bpc_top #(.RST_CYC(RST_CYC)) i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_psel(i_psel),
		.i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_converter_below_ref(below),
		.i_converter_current_limit_hit(cl_hit), .i_converter_overcurrent(i_ocp),
		.i_converter_undervoltage(i_uv), .o_hs_on(o_hs_on), .o_ls_on(o_ls_on),
		.o_converter_reference_level(ref_out), .o_converter_peak_current_limit(cl_out),
		.o_aux_ldo_from_motor_supply(ldo_out), .o_device_reset_req(o_rst_req),
		.o_fault_out_n(o_fault_n), .o_irq(o_irq));

	bpc_load_model i_load (.i_clk(i_clk), .i_resetn(i_resetn), .i_hs_on(o_hs_on), .i_vsel(ref_out),
		.i_cl_sel(cl_out), .i_ovr(ovr), .i_ovr_below(ovr_below), .i_ovr_cl(ovr_cl),
		.o_below_ref(below), .o_cl_hit(cl_hit));

	// ************************************************************
	// Shared tasks
	// ************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Outputs are read right after the edge, before that edge's register updates land.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= wd;
		@(posedge i_clk);
		i_penable <= 1'b1;
		// Only the bench timeout ends a wait for the slave.
		do begin
			@(posedge i_clk);
		end while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic wait_hs(input logic v);
		int n;
		n = 0;
		while (o_hs_on !== v && n < 20) begin
			@(posedge i_clk);
			n++;
		end
	endtask

	always @(posedge i_clk) begin
		cycles++;
		if (cycles > 20000) begin
			bad_count++;
			finish_test();
		end
		if (i_resetn === 1'b1) chk(32'(o_hs_on & o_ls_on), 32'h0);
		if (o_hs_on === 1'b1 && hs_prev !== 1'b1) rises++;
		hs_prev = o_hs_on;
	end

	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic t_reset();
		apb(1'b0, CTRL_OFF, 32'h0);
		chk(rd, 32'h3);
		chk(32'(ldo_out), 32'h1);
		chk(32'(ref_out), 32'h0);
		chk(32'(cl_out), 32'h0);
		chk(32'(o_fault_n), 32'h1);
	endtask

	task automatic t_selects();
		logic [31:0] w;
		for (int v = 0; v < 4; v++) begin
			for (int s = 0; s < 2; s++) begin
				w = 32'((v << 3) | (s << 2) | (s << 1) | 1);
				apb(1'b1, CTRL_OFF, w);
				@(posedge i_clk);
				chk(32'(ref_out), 32'(v));
				chk(32'(ldo_out), 32'(s == 1 || v < 2));
				chk(32'(cl_out), 32'(s));
				apb(1'b0, CTRL_OFF, 32'h0);
				chk(rd, w);
			end
		end
		apb(1'b1, CTRL_OFF, 32'h3);
	endtask

	task automatic t_switch();
		ovr <= 1'b1;
		ovr_below <= 1'b0;
		repeat (4) @(posedge i_clk);
		ovr_below <= 1'b1;
		wait_hs(1'b1);
		chk(32'(o_hs_on), 32'h1);
		ovr_below <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk(32'(o_hs_on), 32'h0);
		ovr_below <= 1'b1;
		wait_hs(1'b1);
		ovr_cl <= 1'b1;
		repeat (2) @(posedge i_clk);
		chk(32'(o_hs_on), 32'h0);
		ovr_cl <= 1'b0;
		repeat (8) @(posedge i_clk);
		chk(32'(o_hs_on), 32'h0);
		ovr_below <= 1'b0;
		repeat (3) @(posedge i_clk);
		ovr_below <= 1'b1;
		wait_hs(1'b1);
		chk(32'(o_hs_on), 32'h1);
		ovr <= 1'b0;
	endtask

	task automatic t_free(input logic [31:0] ctrl);
		int r0;
		apb(1'b1, CTRL_OFF, ctrl);
		r0 = rises;
		repeat (200) @(posedge i_clk);
		chk(32'(rises - r0 > 3), 32'h1);
	endtask

	task automatic t_uv();
		int r0;
		apb(1'b1, MASK_OFF, 32'h7);
		i_uv <= 1'b1;
		@(posedge i_clk);
		i_uv <= 1'b0;
		@(posedge i_clk);
		chk(32'(o_fault_n), 32'h0);
		chk(32'(o_irq), 32'h1);
		r0 = rises;
		repeat (100) @(posedge i_clk);
		chk(32'(rises - r0 > 3), 32'h1);
		apb(1'b0, STATUS_OFF, 32'h0);
		chk(rd, 32'h5);
		apb(1'b1, MASK_OFF, 32'h0);
		chk(32'(o_irq), 32'h0);
		apb(1'b1, STATUS_OFF, 32'h7);
		@(posedge i_clk);
		chk(32'(o_fault_n), 32'h1);
		apb(1'b1, 8'h10, 32'h7);
		chk(32'(err), 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		// Disabling the converter must park both switches; the state word then shows them off.
		apb(1'b1, CTRL_OFF, 32'h6);
		repeat (20) @(posedge i_clk);
		chk(32'(o_hs_on | o_ls_on), 32'h0);
		apb(1'b0, STATE_OFF, 32'h0);
		chk(rd & 32'h57, 32'h4);
		apb(1'b1, STATE_OFF, 32'hFF);
		chk(32'(err), 32'h0);
		apb(1'b1, CTRL_OFF, 32'h7);
	endtask

	task automatic t_ocp();
		int n;
		n = 0;
		ovr <= 1'b1;
		ovr_below <= 1'b1;
		wait_hs(1'b1);
		i_ocp <= 1'b1;
		@(posedge i_clk);
		i_ocp <= 1'b0;
		chk(32'(o_hs_on | o_ls_on), 32'h0);
		while (o_rst_req !== 1'b1 && n < 5) begin
			@(posedge i_clk);
			n++;
		end
		n = 0;
		while (o_rst_req === 1'b1 && n < 50) begin
			@(posedge i_clk);
			n++;
		end
		chk(32'(n), 32'(RST_CYC));
		apb(1'b0, STATUS_OFF, 32'h0);
		chk(rd, 32'h6);
		i_resetn <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		apb(1'b0, STATUS_OFF, 32'h0);
		chk(rd, 32'h0);
		chk(32'(o_fault_n), 32'h1);
		ovr <= 1'b0;
	endtask

	initial begin
		i_resetn = 1'b0;
		{i_psel, i_penable, i_pwrite, i_ocp, i_uv, ovr, ovr_below, ovr_cl} = 8'h00;
		i_paddr = 8'h00;
		i_pwdata = 32'h0;
		repeat (12) @(posedge i_clk);
		i_resetn <= 1'b1;
		@(posedge i_clk);
		t_reset();
		t_selects();
		t_switch();
		t_free(32'h3);
		t_free(32'h7);
		t_uv();
		t_ocp();
		finish_test();
	end
endmodule

/* File: verilog/bpc_gate_ctrl.sv */
// Switch sequencer: pulse-frequency voltage loop with peak current limit and dead time.
`timescale 1ns/10ps
module bpc_gate_ctrl (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Control
	input wire logic i_enable,
	input wire logic i_force_off,
	// Comparators
	input wire logic i_below_ref,
	input wire logic i_cl_hit,
	// Switches and current-limit latch
	output logic o_hs_on,
	output logic o_ls_on,
	output logic o_cl_latched
);
	import bpc_pkg::*;

	typedef enum logic [1:0] {GS_IDLE, GS_HS, GS_DEAD, GS_LS} bpc_gate_type;
	bpc_gate_type state_q, state_d;
	logic cl_latch_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			GS_IDLE: if (i_enable && !i_force_off && i_below_ref && !cl_latch_q) state_d = GS_HS; // [RQ3] [RQ12]
			GS_HS: if (i_force_off || !i_below_ref || i_cl_hit) state_d = GS_DEAD; // [RQ3] [RQ5]
			GS_DEAD: state_d = (i_enable && !i_force_off) ? GS_LS : GS_IDLE; // [RQ13]
			GS_LS: if (i_force_off || !i_enable || (i_below_ref && !cl_latch_q)) state_d = GS_IDLE; // [RQ13]
			default: state_d = GS_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) state_q <= GS_IDLE;
		else state_q <= state_d;
	end

	// A trip holds until the comparator drops; a trip in that same cycle still latches.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) cl_latch_q <= 1'b0;
		else if (state_q == GS_HS && i_cl_hit) cl_latch_q <= 1'b1; // [RQ12]
		else if (!i_below_ref) cl_latch_q <= 1'b0; // [RQ12]
	end

	// Force-off gates the outputs at once so an over-current never waits for the state.
	assign o_hs_on = (state_q == GS_HS) && !i_force_off; // [RQ8]
	assign o_ls_on = (state_q == GS_LS) && !i_force_off; // [RQ8] [RQ13]
	assign o_cl_latched = cl_latch_q;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	sequence hs_request;
		state_q == GS_IDLE && i_enable && !i_force_off && i_below_ref && !cl_latch_q;
	endsequence
	hs_start_a: assert property (hs_request |=> o_hs_on || i_force_off) // [RQ3]
		else $error("High side did not turn on after request.");
	hs_stop_a: assert property (o_hs_on && !i_below_ref |=> !o_hs_on) // [RQ3]
		else $error("High side stayed on after comparator fell.");
	cl_off_a: assert property (o_hs_on && i_cl_hit |=> !o_hs_on && cl_latch_q) // [RQ5]
		else $error("High side stayed on past current limit.");
	cl_hold_a: assert property (cl_latch_q |-> !o_hs_on) // [RQ12]
		else $error("High side restarted before a new request.");
	no_overlap_a: assert property (!(o_hs_on && o_ls_on) && !($fell(o_hs_on) && o_ls_on)) // [RQ13]
		else $error("Both switches commanded together.");
endmodule

/* File: verilog/bpc_reset_pulse.sv */
// Stretches a converter over-current event into a device reset request.
`timescale 1ns/10ps
module bpc_reset_pulse #(
	parameter int unsigned CYC = bpc_pkg::RST_PULSE_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// Event and request
	input wire logic i_trigger,
	output logic o_req
);
	import bpc_pkg::*;

	localparam int unsigned CW = $clog2(CYC + 1);
	logic [CW-1:0] cnt_q;

	// Retriggers are ignored while the request stands; the device reset ends it anyway.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) cnt_q <= '0;
		else if (cnt_q != '0) cnt_q <= cnt_q - 1'b1;
		else if (i_trigger) cnt_q <= CW'(CYC); // [RQ9]
	end

	assign o_req = (cnt_q != '0);

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	pulse_len_a: assert property (!o_req && i_trigger |=> o_req[*8]) // [RQ9]
		else $error("Reset request shorter than expected.");
endmodule

/* File: verilog/bpc_top.sv */
// Buck converter control and supervision with its APB register file.
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
// Summary of operation
// [RQ1] Control bit picks regulator supply: 1 motor supply, 0 converter output, live.
// [RQ2] Converter-output feed only allowed at the 5 V or 5.7 V setting.
// [RQ3] High side on while below-reference comparator high, off when it falls.
// [RQ4] Reference level follows the current output voltage selection.
// [RQ5] High side turns off whenever switch current exceeds the selected limit.
// [RQ6] Under-voltage keeps running, drives fault low, sets driver and UV flags.
// [RQ7] A device reset may clear the under-voltage indication.
// [RQ8] Over-current disables both high-side and low-side switches.
// [RQ9] Every over-current event requests a full device reset; the code ignores one that comes while a request already stands.
// [RQ10] Current-limit select: 0 gives 600 mA, 1 gives 150 mA.
// [RQ11] Voltage select field chooses 3.3 V, 4 V, 5 V or 5.7 V.
// [RQ12] After a current-limit trip, high side waits for a new comparator request.
// [RQ13] High-side and low-side switches never on together.
module bpc_top #(
	parameter int unsigned RST_CYC = bpc_pkg::RST_PULSE_CYC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_resetn,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [bpc_pkg::ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Converter comparators
	input wire logic i_converter_below_ref,
	input wire logic i_converter_current_limit_hit,
	input wire logic i_converter_overcurrent,
	input wire logic i_converter_undervoltage,
	// Converter drive and analog selects
	output logic o_hs_on,
	output logic o_ls_on,
	output bpc_pkg::bpc_vsel_type o_converter_reference_level,
	output logic o_converter_peak_current_limit,
	output logic o_aux_ldo_from_motor_supply,
	// System
	output logic o_device_reset_req,
	output logic o_fault_out_n,
	output logic o_irq
);
	import bpc_pkg::*;

	// ************************************************************
	// APB decode
	// ************************************************************
	logic wr_en;
	logic rd_setup;
	logic acc;
	logic mapped;

	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		return (a == CTRL_OFF) || (a == STATUS_OFF) || (a == MASK_OFF) || (a == STATE_OFF);
	endfunction

	assign acc = i_psel && i_penable;
	assign mapped = is_mapped(i_paddr);
	assign wr_en = acc && i_pwrite && mapped;
	assign rd_setup = i_psel && !i_penable && !i_pwrite;
	// Read data is captured in the setup cycle, so every access completes with no wait state.
	assign o_pready = 1'b1;
	assign o_pslverr = acc && !mapped;

	// ************************************************************
	// Control register
	// ************************************************************
	logic enable_q;
	logic aux_ldo_source_select_q;
	logic converter_current_limit_select_q;
	bpc_vsel_type vsel_q;
	logic wr_ctrl;

	assign wr_ctrl = wr_en && (i_paddr == CTRL_OFF);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			enable_q <= CTRL_EN_RST;
			aux_ldo_source_select_q <= CTRL_LDO_RST;
			converter_current_limit_select_q <= CTRL_CL_RST;
			vsel_q <= VSEL_3V3;
		end else if (wr_ctrl) begin
			enable_q <= i_pwdata[CTRL_EN_BIT];
			aux_ldo_source_select_q <= i_pwdata[CTRL_LDO_BIT]; // [RQ1]
			converter_current_limit_select_q <= i_pwdata[CTRL_CL_BIT]; // [RQ10]
			vsel_q <= bpc_vsel_type'(i_pwdata[CTRL_VSEL_LSB +: 2]); // [RQ11]
		end
	end

	// ************************************************************
	// Analog selects
	// ************************************************************
	// A converter feed request at a low output setting falls back to the motor supply,
	// since the converter output would then be too close to the regulator output.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_aux_ldo_from_motor_supply <= LDO_SRC_MOTOR;
			o_converter_reference_level <= VSEL_3V3;
			o_converter_peak_current_limit <= CL_SEL_600MA;
		end else begin
			o_aux_ldo_from_motor_supply <= aux_ldo_source_select_q || !bpc_buck_feed_ok(vsel_q); // [RQ1] [RQ2]
			o_converter_reference_level <= vsel_q; // [RQ4] [RQ11]
			o_converter_peak_current_limit <= converter_current_limit_select_q; // [RQ10]
		end
	end

	// ************************************************************
	// Switch sequencing and over-current reset
	// ************************************************************
	logic force_off;
	logic cl_latched;

	assign force_off = i_converter_overcurrent || o_device_reset_req || !enable_q; // [RQ8]

	bpc_gate_ctrl u_gate (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_enable(enable_q),
		.i_force_off(force_off),
		.i_below_ref(i_converter_below_ref),
		.i_cl_hit(i_converter_current_limit_hit),
		.o_hs_on(o_hs_on),
		.o_ls_on(o_ls_on),
		.o_cl_latched(cl_latched)
	);

	bpc_reset_pulse #(
		.CYC(RST_CYC)
	) u_rst (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.i_trigger(i_converter_overcurrent), // [RQ9]
		.o_req(o_device_reset_req)
	);

	// ************************************************************
	// Status, mask, interrupt and fault pin
	// ************************************************************
	logic [STAT_W-1:0] status_q;
	logic [STAT_W-1:0] status_d;
	logic [STAT_W-1:0] mask_q;
	logic [STAT_W-1:0] events;
	logic [STAT_W-1:0] w1c;

	always_comb begin
		events = '0;
		events[STAT_UV_BIT] = i_converter_undervoltage; // [RQ6]
		events[STAT_OCP_BIT] = i_converter_overcurrent;
		events[STAT_DRV_BIT] = i_converter_undervoltage || i_converter_overcurrent; // [RQ6]
		w1c = (wr_en && i_paddr == STATUS_OFF) ? i_pwdata[STAT_W-1:0] : '0;
		// An event in the clearing cycle survives the clear.
		status_d = (status_q & ~w1c) | events;
	end

	// Nothing here survives a device reset, so an under-voltage flagged before one is forgotten.
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) status_q <= STAT_RST; // [RQ7]
		else status_q <= status_d;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) mask_q <= MASK_RST;
		else if (wr_en && i_paddr == MASK_OFF) mask_q <= i_pwdata[STAT_W-1:0];
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) o_fault_out_n <= 1'b1; // [RQ7]
		else o_fault_out_n <= !(|status_d); // [RQ6]
	end

	assign o_irq = |(status_q & mask_q);

	// ************************************************************
	// Read data
	// ************************************************************
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = '0;
		case (i_paddr)
			CTRL_OFF: begin
				rd_mux[CTRL_EN_BIT] = enable_q;
				rd_mux[CTRL_LDO_BIT] = aux_ldo_source_select_q;
				rd_mux[CTRL_CL_BIT] = converter_current_limit_select_q;
				rd_mux[CTRL_VSEL_LSB +: 2] = vsel_q;
			end
			STATUS_OFF: rd_mux[STAT_W-1:0] = status_q;
			MASK_OFF: rd_mux[STAT_W-1:0] = mask_q;
			STATE_OFF: begin
				rd_mux[ST_HS_BIT] = o_hs_on;
				rd_mux[ST_LS_BIT] = o_ls_on;
				rd_mux[ST_LDO_BIT] = o_aux_ldo_from_motor_supply;
				rd_mux[ST_CMP_BIT] = i_converter_below_ref;
				rd_mux[ST_UV_BIT] = i_converter_undervoltage;
				rd_mux[ST_CLL_BIT] = cl_latched;
				rd_mux[ST_RRQ_BIT] = o_device_reset_req;
			end
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) o_prdata <= '0;
		else if (rd_setup) o_prdata <= rd_mux;
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	sequence ctrl_write_buck_feed;
		wr_ctrl && !i_pwdata[CTRL_LDO_BIT] && i_pwdata[CTRL_VSEL_LSB + 1];
	endsequence
	sequence ctrl_write_low_vsel;
		wr_ctrl && !i_pwdata[CTRL_VSEL_LSB + 1];
	endsequence

	ldo_switch_a: assert property (ctrl_write_buck_feed |-> ##2 !o_aux_ldo_from_motor_supply) // [RQ1]
		else $error("Regulator did not change over to converter feed.");
	ldo_guard_a: assert property (ctrl_write_low_vsel |-> ##2 o_aux_ldo_from_motor_supply) // [RQ2]
		else $error("Converter feed allowed at a low output setting.");
	ref_track_a: assert property (wr_ctrl |-> ##2 o_converter_reference_level == $past(i_pwdata[CTRL_VSEL_LSB +: 2], 2)) // [RQ4]
		else $error("Reference level does not follow voltage select.");
	cl_code_a: assert property (wr_ctrl |-> ##2 o_converter_peak_current_limit == $past(i_pwdata[CTRL_CL_BIT], 2)) // [RQ10]
		else $error("Current limit select not applied.");
	uv_flag_a: assert property (i_converter_undervoltage |=> status_q[STAT_UV_BIT] && status_q[STAT_DRV_BIT] && !o_fault_out_n) // [RQ6]
		else $error("Under-voltage not reported.");
	ocp_off_a: assert property (i_converter_overcurrent |-> !o_hs_on && !o_ls_on) // [RQ8]
		else $error("Switches left on during over-current.");
	ocp_reset_a: assert property (i_converter_overcurrent && !o_device_reset_req |=> o_device_reset_req[*4]) // [RQ9]
		else $error("Over-current did not request device reset.");
	irq_level_a: assert property (status_q[STAT_OCP_BIT] && mask_q[STAT_OCP_BIT] |-> o_irq)
		else $error("Unmasked status did not raise interrupt.");
endmodule
